/* core/iwk_pkg.sv */
// constants and types shared by the i/o wake-up configuration block
package iwk_pkg;

   // device clock
   localparam int CLK_HZ = 40_000_000;

   // spi frame layout
   localparam int FRAME_BITS = 16;
   localparam int RW_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 9;
   localparam int PAR_BIT = 8;
   localparam int ADDR_CAPTURE_CNT = 6;
   localparam logic [4:0] FRAME_LAST_CNT = 5'h0F;
   localparam logic [4:0] FRAME_DONE_CNT = 5'h10;
   localparam logic [4:0] LOW_BYTE_CNT = 5'h08;

   // register addresses in frame bits 14..9
   localparam logic [5:0] ADDR_WAKE_CFG_FIRST = 6'h04;
   localparam logic [5:0] ADDR_WAKE_CFG_SECOND = 6'h05;

   // power-on values of the two configuration bytes
   localparam logic [7:0] WAKE_CFG_FIRST_RST = 8'h00;
   localparam logic [7:0] WAKE_CFG_SECOND_RST = 8'h00;

   // field positions: edge fields are two bits wide, lsb given
   localparam int NUM_IO = 6;
   localparam int EDGE_POS [0:5] = '{6, 4, 2, 6, 4, 2};
   localparam int EDGE_REG [0:5] = '{0, 0, 0, 1, 1, 1};
   localparam int MASK_IN0_POS = 0;
   localparam int MASK_IN1_POS = 1;
   localparam int MASK_IN23_POS = 1;
   localparam int MASK_IN45_POS = 0;

   // status byte positions
   localparam int STAT_IO_POS = 3;

   // edge selection codes
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_ANY = 2'h3
   } iwk_edge_e;

   // interrupt pulse widths
   localparam int INT_LONG_US = 100;
   localparam int INT_SHORT_US = 25;
   localparam logic [11:0] INT_LONG_CYC = 12'(INT_LONG_US * (CLK_HZ / 1_000_000));
   localparam logic [11:0] INT_SHORT_CYC = 12'(INT_SHORT_US * (CLK_HZ / 1_000_000));

endpackage

/* core/iwk_sync.sv */
// three-stage synchroniser that reports a level once stages two and three agree
module iwk_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // level in and settled level out
   input wire logic d,
   output logic q
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic q_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // one-cycle glitches past stage two never reach q
         if (s2_r == s3_r) begin
            q_r <= s3_r;
         end
      end
   end

   assign q = q_r;

endmodule

/* core/iwk_wake_cfg.sv */
// wake-up edge selection and interrupt masking for six i/o inputs, set over spi
module iwk_wake_cfg
   import iwk_pkg::*;
(
   // device clock and power-on reset
   input wire logic clk,
   input wire logic resetn,
   // warm reset pulse, clk domain
   input wire logic warm_reset,
   // spi link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe_n,
   // general i/o inputs
   input wire logic [5:0] io_in,
   // global summary flags from the rest of the chip, clk domain
   input wire logic stat_spi,
   input wire logic stat_wake,
   input wire logic stat_can,
   input wire logic stat_lin,
   input wire logic stat_vpre,
   input wire logic stat_vcore,
   input wire logic stat_vothers,
   // interrupt control
   input wire logic int_short_sel,
   input wire logic io_flag_clr,
   // event outputs
   output logic int_n,
   output logic wake_pulse,
   output logic io_group_flag
);

   // configuration and snapshot
   logic [7:0] cfg1_r;
   logic [7:0] cfg1_nxt;
   logic [7:0] cfg2_r;
   logic [7:0] cfg2_nxt;
   logic [23:0] snap_r;
   logic [7:0] status_byte;

   // spi link side
   logic [4:0] cnt_r;
   logic [15:0] sh_r;
   logic [5:0] addr_r;
   logic [15:0] rx_word_r;
   logic rx_tgl_r;
   logic [7:0] reply_low;
   logic [15:0] reply_word;
   logic [3:0] bit_idx;

   // frame hand-over into clk
   logic cs_q;
   logic tgl_q;
   logic tgl_prev_r;
   logic frame_new;
   logic frame_wr;
   logic [5:0] frame_addr;
   logic par_ok;
   logic wr_first;
   logic wr_second;

   // i/o event path
   logic [5:0] io_q;
   logic [5:0] io_prev_r;
   logic [5:0] rise;
   logic [5:0] fall;
   logic [5:0] wake_ev;
   logic [5:0] int_ev;
   logic [5:0] mask_vec;
   logic any_int;
   logic int_start;
   logic [11:0] int_cnt_r;
   logic [11:0] int_cnt_nxt;
   logic [11:0] int_len;
   logic io_flag_r;
   logic wake_pulse_r;

   // link logic: frame state cleared by chip select itself, since sclk stops between frames
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         addr_r <= 6'h00;
      end else begin
         if (cnt_r != FRAME_DONE_CNT) begin
            cnt_r <= cnt_r + 5'h01;
         end
         sh_r <= {sh_r[14:0], mosi};
         if (cnt_r == 5'(ADDR_CAPTURE_CNT)) begin
            addr_r <= {sh_r[4:0], mosi};
         end
      end
   end

   // complete word held until the next frame's sixteenth edge
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rx_word_r <= 16'h0000;
         rx_tgl_r <= 1'b0;
      end else if (!cs_n && cnt_r == FRAME_LAST_CNT) begin
         rx_word_r <= {sh_r[14:0], mosi};
         rx_tgl_r <= ~rx_tgl_r;
      end
   end

   // reply: status first, then the addressed configuration byte
   assign reply_low = (addr_r == ADDR_WAKE_CFG_FIRST) ? snap_r[15:8] :
                      (addr_r == ADDR_WAKE_CFG_SECOND) ? snap_r[7:0] : 8'h00;
   assign reply_word = {snap_r[23:16], reply_low};
   assign bit_idx = 4'hF - cnt_r[3:0];
   assign miso_o = (cnt_r < FRAME_DONE_CNT) ? reply_word[bit_idx] : 1'b0;
   assign miso_oe_n = cs_n;

   // crossings into clk
   iwk_sync #(.RST_VAL(1'b1)) u_cs_sync (
      .clk(clk),
      .resetn(resetn),
      .d(cs_n),
      .q(cs_q)
   );

   iwk_sync #(.RST_VAL(1'b0)) u_tgl_sync (
      .clk(clk),
      .resetn(resetn),
      .d(rx_tgl_r),
      .q(tgl_q)
   );

   // frame decode
   assign frame_new = tgl_q ^ tgl_prev_r;
   assign frame_wr = rx_word_r[RW_BIT];
   assign frame_addr = rx_word_r[ADDR_HI:ADDR_LO];
   // odd parity across the whole frame, bit8 included
   assign par_ok = ^rx_word_r;
   assign wr_first = frame_new && frame_wr && par_ok && frame_addr == ADDR_WAKE_CFG_FIRST;
   assign wr_second = frame_new && frame_wr && par_ok && frame_addr == ADDR_WAKE_CFG_SECOND;
   assign cfg1_nxt = wr_first ? rx_word_r[7:0] : cfg1_r;
   assign cfg2_nxt = wr_second ? rx_word_r[7:0] : cfg2_r;

   assign status_byte = {stat_spi, stat_wake, stat_can, stat_lin,
                         io_flag_r, stat_vpre, stat_vcore, stat_vothers};

   // only power-on reset touches the configuration; warm reset is ignored here
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg1_r <= WAKE_CFG_FIRST_RST;
         cfg2_r <= WAKE_CFG_SECOND_RST;
         tgl_prev_r <= 1'b0;
      end else begin
         cfg1_r <= cfg1_nxt;
         cfg2_r <= cfg2_nxt;
         tgl_prev_r <= tgl_q;
      end
   end

   // snapshot frozen while a frame runs so the link reads a steady word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         snap_r <= 24'h000000;
      end else if (cs_q) begin
         snap_r <= {status_byte, cfg1_nxt, cfg2_nxt};
      end
   end

   // per-input masks
   assign mask_vec = {cfg2_r[MASK_IN45_POS], cfg2_r[MASK_IN45_POS],
                      cfg2_r[MASK_IN23_POS], cfg2_r[MASK_IN23_POS],
                      cfg1_r[MASK_IN1_POS],
                      cfg1_r[MASK_IN0_POS]};

   // edge detection per input
   for (genvar i = 0; i < NUM_IO; i++) begin : g_io
      logic [1:0] sel;

      iwk_sync #(.RST_VAL(1'b0)) u_io_sync (
         .clk(clk),
         .resetn(resetn),
         .d(io_in[i]),
         .q(io_q[i])
      );

      assign sel = (EDGE_REG[i] == 1) ? cfg2_r[EDGE_POS[i] +: 2] : cfg1_r[EDGE_POS[i] +: 2];
      assign rise[i] = io_q[i] & ~io_prev_r[i];
      assign fall[i] = ~io_q[i] & io_prev_r[i];
      // bit0 of the code enables rising, bit1 falling, both give any edge
      assign wake_ev[i] = (sel[0] & rise[i]) | (sel[1] & fall[i]);
      assign int_ev[i] = wake_ev[i] & ~mask_vec[i];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_prev_r <= 6'h00;
      end else begin
         io_prev_r <= io_q;
      end
   end

   // interrupt pulse; events during a running pulse merge into it
   assign any_int = |int_ev;
   assign int_start = any_int && int_cnt_r == 12'h000;
   assign int_len = int_short_sel ? INT_SHORT_CYC : INT_LONG_CYC;
   assign int_cnt_nxt = int_start ? int_len :
                        (int_cnt_r != 12'h000) ? int_cnt_r - 12'h001 : 12'h000;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_cnt_r <= 12'h000;
         wake_pulse_r <= 1'b0;
      end else begin
         int_cnt_r <= int_cnt_nxt;
         wake_pulse_r <= |wake_ev;
      end
   end

   // summary flag: a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_flag_r <= 1'b0;
      end else if (any_int) begin
         io_flag_r <= 1'b1;
      end else if (io_flag_clr || warm_reset) begin
         io_flag_r <= 1'b0;
      end
   end

   assign int_n = (int_cnt_r == 12'h000);
   assign wake_pulse = wake_pulse_r;
   assign io_group_flag = io_flag_r;

   // helper logic for the pulse width check
   logic [11:0] low_len_r;
   logic short_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_len_r <= 12'h000;
         short_r <= 1'b0;
      end else begin
         low_len_r <= int_n ? 12'h000 : low_len_r + 12'h001;
         if (int_start) begin
            short_r <= int_short_sel;
         end
      end
   end

   sequence s_pulse_end;
      $rose(int_n);
   endsequence

   pulse_width_a: assert property (@(posedge clk) disable iff (!resetn)
      s_pulse_end |-> low_len_r == (short_r ? INT_SHORT_CYC : INT_LONG_CYC))
      else $error("interrupt pulse width wrong");

   edge_in2_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg1_r[3:2] == EDGE_RISE && fall[2] && !(|wake_ev[5:3]) && !(|wake_ev[1:0])) |=> !wake_pulse)
      else $error("input 2 woke on falling edge with rising mode");

   edge_in3_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg2_r[7:6] == EDGE_ANY && (rise[3] || fall[3])) |=> wake_pulse)
      else $error("input 3 any-edge wake missed");

   edge_in4_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg2_r[5:4] == EDGE_NONE) |-> !wake_ev[4])
      else $error("input 4 woke with wake disabled");

   edge_in5_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg2_r[3:2] == EDGE_FALL) |-> (wake_ev[5] == fall[5]))
      else $error("input 5 falling mode wrong");

   edge_in0_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg1_r[7:6] == EDGE_RISE) |-> (wake_ev[0] == rise[0]))
      else $error("input 0 rising mode wrong");

   mask_in1_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg1_r[MASK_IN1_POS] && int_n && !(|int_ev[5:2]) && !int_ev[0]) |=> int_n)
      else $error("masked input 1 raised an interrupt");

   flag_in0_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg1_r[MASK_IN0_POS] && !io_flag_r && !(|int_ev[5:1])) |=> !io_flag_r)
      else $error("masked input 0 set the summary flag");

   flag_in1_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg1_r[MASK_IN1_POS] && wake_ev[1] && !io_flag_r && !(|int_ev[5:2]) && !int_ev[0]) |=> !io_flag_r)
      else $error("masked input 1 set the summary flag");

   mask_45_a: assert property (@(posedge clk) disable iff (!resetn)
      (cfg2_r[MASK_IN45_POS] && int_n && !(|int_ev[3:0])) |=> int_n)
      else $error("masked inputs 4 or 5 raised an interrupt");

   mask_23_a: assert property (@(posedge clk) disable iff (!resetn)
      cfg2_r[MASK_IN23_POS] |-> (int_ev[3:2] == 2'b00))
      else $error("masked inputs 2 or 3 produced an event");

   write_second_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_second |=> cfg2_r == $past(rx_word_r[7:0]))
      else $error("second register write not taken");

   read_keeps_a: assert property (@(posedge clk) disable iff (!resetn)
      (frame_new && !frame_wr) |=> ($stable(cfg1_r) && $stable(cfg2_r)))
      else $error("read frame changed configuration");

   warm_keeps_a: assert property (@(posedge clk) disable iff (!resetn)
      (warm_reset && !frame_new) |=> ($stable(cfg1_r) && $stable(cfg2_r)))
      else $error("warm reset changed configuration");

   one_event_a: assert property (@(posedge clk) disable iff (!resetn)
      wake_ev[0] |=> !wake_ev[0])
      else $error("one edge gave two events");

   status_msb_a: assert property (@(posedge sclk) disable iff (cs_n)
      (cnt_r == 5'h00) |-> (miso_o == snap_r[23]))
      else $error("reply does not start with interface flag");

   reply_low_a: assert property (@(posedge sclk) disable iff (cs_n)
      (cnt_r == LOW_BYTE_CNT && addr_r == ADDR_WAKE_CFG_SECOND) |-> (miso_o == snap_r[7]))
      else $error("second register reply bit7 wrong");

   // an unmasked event with no pulse running must start one
   sequence s_unmasked_event;
      any_int && int_n;
   endsequence

   int_start_a: assert property (@(posedge clk) disable iff (!resetn)
      s_unmasked_event |=> !int_n)
      else $error("unmasked event gave no interrupt pulse");

   flag_set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
      (any_int && (io_flag_clr || warm_reset)) |=> io_flag_r)
      else $error("clear beat a new event on the summary flag");

endmodule

/* tb/iwk_host.sv */
// spi host model that sends one frame at a time and hands back the reply
module iwk_host (
   // device clock, used only to space frames
   input wire logic clk,
   // spi link
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   // reply of the last frame and its strobe
   output logic [15:0] rx_word,
   output logic rx_stb
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {sclk, mosi, rx_stb} = 3'h0;
      cs_n = 1'b1;
      rx_word = 16'h0000;
   end
   // sclk stands low between frames; mosi flips after the frame, so a stale bit is never read as valid
   task automatic xfer(input logic [15:0] w);
      logic [15:0] r;
      r = 16'h0000;
      // chip select moves off the clock edge so its synchroniser never races it
      #2 cs_n = 1'b0;
      repeat (6) @(posedge clk);
      #7;
      for (int k = 15; k >= 0; k--) begin
         mosi = w[k];
         #15;
         r[k] = (miso_oe_n === 1'b0) ? miso_o : 1'bx;
         sclk = 1'b1;
         #15;
         sclk = 1'b0;
      end
      #15;
      mosi = ~mosi;
      repeat (8) @(posedge clk);
      #2 cs_n = 1'b1;
      rx_word = r;
      rx_stb = 1'b1;
      #1;
      rx_stb = 1'b0;
      repeat (12) @(posedge clk);
   endtask
endmodule

/* tb/iwk_wake_cfg_tb_top.sv */
// self-checking bench for the i/o wake-up configuration block
module iwk_wake_cfg_tb_top
   import iwk_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, resetn, warm_reset, sclk, cs_n, mosi, miso_o, miso_oe_n;
   logic int_short_sel, io_flag_clr, int_n, wake_pulse, io_group_flag, rx_stb, flag_e;
   logic [5:0] io_in;
   logic [6:0] stat;
   logic [15:0] rx_word;
   logic [15:0] rq[$];
   logic wq[$];
   logic [7:0] cfg_e [0:1];
   logic [7:0] b [0:1];
   logic [11:0] exp_w;
   int lowcnt, cyc, failures, checks;

   iwk_wake_cfg iwk_wake_cfg_i (.clk(clk), .resetn(resetn), .warm_reset(warm_reset), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .io_in(io_in), .stat_spi(stat[6]),
      .stat_wake(stat[5]), .stat_can(stat[4]), .stat_lin(stat[3]), .stat_vpre(stat[2]), .stat_vcore(stat[1]),
      .stat_vothers(stat[0]), .int_short_sel(int_short_sel), .io_flag_clr(io_flag_clr), .int_n(int_n),
      .wake_pulse(wake_pulse), .io_group_flag(io_group_flag));
   iwk_host iwk_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
      .miso_oe_n(miso_oe_n), .rx_word(rx_word), .rx_stb(rx_stb));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic [15:0] rep(input logic [7:0] low);
      return {stat[6:3], flag_e, stat[2:0], low};
   endfunction

   // odd parity over the whole frame
   function automatic logic [15:0] mk(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] w;
      w = {1'b1, a, 1'b0, d};
      w[PAR_BIT] = ~(^w);
      return w;
   endfunction

   function automatic logic [5:0] adr(input int r);
      return (r == 1) ? ADDR_WAKE_CFG_SECOND : ADDR_WAKE_CFG_FIRST;
   endfunction

   task automatic raw(input logic [15:0] w, input logic [7:0] low);
      @(posedge clk);
      #2 stat = 7'($urandom);
      repeat (8) @(posedge clk);
      rq.push_back(rep(low));
      iwk_host_i.xfer(w);
   endtask

   task automatic wr(input int r, input logic [7:0] d);
      raw(mk(adr(r), d), cfg_e[r]);
      cfg_e[r] = d;
   endtask

   task automatic rd(input int r);
      raw({1'b0, adr(r), 9'h000}, cfg_e[r]);
   endtask

   task automatic ev(input int i, input logic v, input logic en, input logic unm);
      if (en) wq.push_back(~unm);
      if (en && unm) flag_e = 1'b1;
      @(posedge clk);
      #2 io_in[i] = v;
      repeat (12) @(posedge clk);
      #2 chk(io_group_flag === flag_e, "summary flag");
      if (en && unm) repeat (int'(exp_w) + 8) @(posedge clk);
   endtask

   task automatic pulse(input int which);
      @(posedge clk);
      #2 if (which == 0) io_flag_clr = 1'b1; else warm_reset = 1'b1;
      @(posedge clk);
      #2 {io_flag_clr, warm_reset} = 2'h0;
      flag_e = 1'b0;
   endtask

   task automatic por();
      @(posedge clk);
      #2 resetn = 1'b0;
      repeat (16) @(posedge clk);
      #2 resetn = 1'b1;
      cfg_e = '{WAKE_CFG_FIRST_RST, WAKE_CFG_SECOND_RST};
      flag_e = 1'b0;
      repeat (8) @(posedge clk);
   endtask

   // one note per expected wake pulse; extra or missing pulses show up as a queue mismatch
   // outputs are looked at on the falling edge, where they have settled
   always @(negedge clk) begin
      if (wake_pulse === 1'b1) begin
         if (wq.size() == 0) chk(1'b0, "unexpected wake pulse");
         else chk(int_n === wq.pop_front(), "interrupt on event");
      end
      if (int_n === 1'b0) lowcnt++;
      else if (lowcnt != 0) begin
         chk(lowcnt == int'(exp_w), "pulse width");
         lowcnt = 0;
      end
      cyc++;
      if (cyc == 60000) begin
         chk(1'b0, "timeout");
         complete_run();
      end
   end

   always @(posedge rx_stb) begin
      chk(rx_word === rq.pop_front(), "spi reply");
   end

   initial begin
      {resetn, warm_reset, io_flag_clr, flag_e} = 4'h0;
      {io_in, stat} = 13'h0000;
      int_short_sel = 1'b1;
      exp_w = INT_SHORT_CYC;
      {lowcnt, cyc, failures, checks} = {32'h0, 32'h0, 32'h0, 32'h0};
      cfg_e = '{WAKE_CFG_FIRST_RST, WAKE_CFG_SECOND_RST};
      void'($urandom(32'h6FFBE0FC));
      repeat (16) @(posedge clk);
      #2 resetn = 1'b1;
      repeat (8) @(posedge clk);
      rd(0);
      rd(1);
      for (int i = 0; i < NUM_IO; i++) begin
         for (int c = 0; c < 4; c++) begin
            wr(EDGE_REG[i], 8'(c << EDGE_POS[i]));
            ev(i, 1'b1, 1'(c), 1'b1);
            ev(i, 1'b0, 1'(c >> 1), 1'b1);
         end
      end
      // fail-safe style use: every input masked while still waking
      for (int i = 0; i < NUM_IO; i++) begin
         pulse(0);
         b = '{8'h00, 8'h00};
         b[EDGE_REG[i]] |= 8'(3 << EDGE_POS[i]);
         b[i / 2 == 0 ? 0 : 1] |= 8'(1 << (i == 0 ? MASK_IN0_POS : i == 1 ? MASK_IN1_POS :
            i < 4 ? MASK_IN23_POS : MASK_IN45_POS));
         wr(0, b[0]);
         wr(1, b[1]);
         ev(i, 1'b1, 1'b1, 1'b0);
         ev(i, 1'b0, 1'b1, 1'b0);
         rd(1);
      end
      @(posedge clk);
      #2 int_short_sel = 1'b0;
      exp_w = INT_LONG_CYC;
      wr(1, 8'h00);
      wr(0, 8'hC0);
      ev(0, 1'b1, 1'b1, 1'b1);
      rd(0);
      pulse(1);
      rd(0);
      rd(1);
      raw(mk(ADDR_WAKE_CFG_SECOND, 8'h5A) ^ 16'h0100, cfg_e[1]);
      rd(1);
      raw({1'b0, 6'h3F, 9'h000}, 8'h00);
      wr(1, 8'($urandom));
      rd(1);
      por();
      rd(0);
      rd(1);
      chk(wq.size() == 0 && rq.size() == 0, "missing results");
      complete_run();
   end
endmodule
